// >>> ohp_cfg.svh
// Constants for the opcode handshake port: offsets, fields, codes and resets.
// Assumes inclusion by bare name from the package and the design module.
`ifndef OHP_CFG_SVH
`define OHP_CFG_SVH
`define OHP_ADR_DATA 8'h00
`define OHP_ADR_HSK 8'h04
`define OHP_ADR_MODE 8'h08
`define OHP_ADR_EVT 8'h0c
`define OHP_HSK_WR_BIT 0
`define OHP_HSK_RD_BIT 1
`define OHP_CMD_MSB 15
`define OHP_CMD_LSB 8
`define OHP_OBJ_MSB 7
`define OHP_OBJ_LSB 0
`define OHP_CH_MAX_WIDE 8'h7f
`define OHP_CH_MAX_NARROW 8'h3f
`define OHP_CHIP_MAX_WIDE 8'h03
`define OHP_CHIP_MAX_NARROW 8'h01
`define OHP_OP_MATCH 8'h00
`define OHP_OP_STREAM 8'h01
`define OHP_OP_MODE_Q 8'h02
`define OHP_OP_KEEP_ON 8'h03
`define OHP_OP_KEEP_OFF 8'h04
`define OHP_OP_FACTORY 8'h05
`define OHP_OP_SAVE 8'h06
`define OHP_OP_LOAD 8'h07
`define OHP_OP_BOOT_CUST 8'h08
`define OHP_OP_BOOT_FACT 8'h09
`define OHP_OP_WIN_W 8'h10
`define OHP_OP_WIN_O 8'h11
`define OHP_OP_SRCH 8'h12
`define OHP_OP_REJ 8'h13
`define OHP_OP_SUB_ON 8'h14
`define OHP_OP_SUB_OFF 8'h15
`define OHP_OP_TRG_Q 8'h16
`define OHP_OP_DET_W 8'h22
`define OHP_OP_DET_Q 8'h23
`define OHP_OP_STEP_W 8'h24
`define OHP_OP_PAIR_W 8'h25
`define OHP_OP_RES_Q 8'h26
`define OHP_OP_DEAD_W 8'h28
`define OHP_OP_DEAD_Q 8'h29
`define OHP_OP_FRM_ON 8'h30
`define OHP_OP_FRM_OFF 8'h31
`define OHP_OP_FRM_Q 8'h32
`define OHP_OP_EVT_W 8'h33
`define OHP_OP_EVT_Q 8'h34
`define OHP_OP_CH_ON 8'h40
`define OHP_OP_CH_OFF 8'h41
`define OHP_OP_ID_Q 8'h60
`define OHP_RST_WIN_W 12'h014
`define OHP_RST_WIN_O 12'hfd8
`define OHP_RST_SRCH 12'h008
`define OHP_RST_REJ 12'h004
`define OHP_RST_PAIR 16'h0000
`define OHP_RST_EVT 16'h0000
`endif

// >>> ohp_pkg.sv
// Types for the opcode handshake port.
// Assumes ohp_cfg.svh sits in the include path.
package ohp_pkg;
  `include "ohp_cfg.svh"
  // Operation word: command in the high byte, target in the low byte.
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] obj;
  } ohp_op_t;
  // Reprogram class of a command.
  typedef enum logic [1:0] {OHP_RP_NONE, OHP_RP_SETUP, OHP_RP_CTRL} ohp_rp_t;
  // Decoded command table entry.
  typedef struct packed {
    logic [2:0] write_operand_count;
    logic [2:0] read_operand_count;
    ohp_rp_t reprogram_class;
  } ohp_ent_t;
endpackage : ohp_pkg

// >>> ohp_port.sv
// Command interpreter behind a classic Wishbone slave for a multihit converter board.
// Assumes a single 100 MHz clock, a synchronous reset and a host that polls the handshake.
`timescale 1ns/1ps
`include "ohp_cfg.svh"
module ohp_port
  import ohp_pkg::*;
#(
  parameter bit WIDE = 1'b1 // One for the 128-channel variant.
) (
  input wire logic clk_i, // 100 MHz clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Byte address.
  input wire logic [3:0] wb_sel_i, // Byte selects.
  input wire logic [31:0] wb_dat_i, // Write data.
  output logic [31:0] wb_dat_o, // Read data.
  output logic wb_ack_o, // Acknowledge.
  output logic setup_reprog_o, // Pulse: reprogram setup registers.
  output logic ctrl_reprog_o, // Pulse: reprogram control registers.
  output logic data_clear_o, // Pulse: clear acquired data.
  output logic window_match_select_o, // Level: window match mode active.
  output logic auto_reject_o, // Level: automatic rejection on.
  output logic hold_token_o, // Level: chips hold token to event end.
  output logic trigger_subtract_o, // Level: trigger time subtraction on.
  output logic frame_words_o, // Level: chip header and trailer on.
  output logic boot_custom_o, // Level: boot from saved user setup.
  output logic [127:0] ch_enable_o // Per-channel enable.
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  typedef enum {ST_IDLE, ST_WRITE, ST_READ} ohp_st_t;
  ohp_st_t st_q;
  logic req;
  logic wr_data;
  logic rd_data;
  logic [15:0] wdat;
  logic write_avail_bit_q;
  logic read_avail_bit_q;
  logic [15:0] rd_word_q;
  logic [2:0] wleft_q;
  logic [2:0] rleft_q;
  logic [2:0] ridx_q;
  ohp_op_t op_q;
  ohp_op_t op_in;
  ohp_ent_t ent;
  logic obj_ok;

  // A request is answered one cycle after it is seen; ack then drops.
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wdat = wb_dat_i[15:0];
  assign op_in = wdat;
  // Words sent while the flag is low are dropped without effect.
  assign wr_data = req && wb_we_i && wb_sel_i[0] && wb_sel_i[1]
    && (wb_adr_i == `OHP_ADR_DATA) && write_avail_bit_q;
  assign rd_data = req && !wb_we_i && (wb_adr_i == `OHP_ADR_DATA) && read_avail_bit_q;

  // Acknowledge every access, mapped or not.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // ----------------------------------------------------------------
  // Command table
  // ----------------------------------------------------------------
  // Table lines this port acts on are decoded, except the boot codes, which take the default; other codes end at once.
  always_comb
  begin
    ent = '{3'd0, 3'd0, OHP_RP_NONE};
    case (op_in.cmd)
      `OHP_OP_MATCH, `OHP_OP_STREAM, `OHP_OP_KEEP_ON, `OHP_OP_KEEP_OFF,
      `OHP_OP_FACTORY, `OHP_OP_LOAD, `OHP_OP_SUB_ON, `OHP_OP_SUB_OFF,
      `OHP_OP_FRM_ON, `OHP_OP_FRM_OFF:
        ent = '{3'd0, 3'd0, OHP_RP_SETUP};
      `OHP_OP_MODE_Q, `OHP_OP_DET_Q, `OHP_OP_RES_Q, `OHP_OP_DEAD_Q,
      `OHP_OP_FRM_Q, `OHP_OP_EVT_Q:
        ent = '{3'd0, 3'd1, OHP_RP_NONE};
      `OHP_OP_TRG_Q:
        ent = '{3'd0, 3'd5, OHP_RP_NONE};
      `OHP_OP_WIN_W, `OHP_OP_WIN_O, `OHP_OP_SRCH, `OHP_OP_REJ,
      `OHP_OP_DET_W, `OHP_OP_STEP_W, `OHP_OP_PAIR_W, `OHP_OP_DEAD_W,
      `OHP_OP_EVT_W:
        ent = '{3'd1, 3'd0, OHP_RP_SETUP};
      `OHP_OP_CH_ON, `OHP_OP_CH_OFF:
        ent = '{3'd0, 3'd0, OHP_RP_CTRL};
      `OHP_OP_ID_Q:
        ent = '{3'd0, 3'd2, OHP_RP_NONE};
      default:
        ent = '{3'd0, 3'd0, OHP_RP_NONE};
    endcase
  end

  // Range check of targeted objects; others ignore the field entirely.
  always_comb
  begin
    obj_ok = 1'b1;
    if (op_in.cmd == `OHP_OP_CH_ON || op_in.cmd == `OHP_OP_CH_OFF)
      obj_ok = op_in.obj <= (WIDE ? `OHP_CH_MAX_WIDE : `OHP_CH_MAX_NARROW);
    else if (op_in.cmd == `OHP_OP_ID_Q)
      obj_ok = op_in.obj <= (WIDE ? `OHP_CHIP_MAX_WIDE : `OHP_CHIP_MAX_NARROW);
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [11:0] win_w_q, win_o_q, srch_q, rej_q;
  logic [1:0] det_q, step_q, dead_q;
  logic [15:0] pair_q, evt_q;
  logic [15:0] rd_next;

  // State and operand counters; an out-of-range target is dropped at once.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= ST_IDLE;
      op_q <= '0;
      wleft_q <= 3'd0;
      rleft_q <= 3'd0;
      ridx_q <= 3'd0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (wr_data && obj_ok)
          begin
            op_q <= op_in;
            wleft_q <= ent.write_operand_count;
            rleft_q <= ent.read_operand_count;
            ridx_q <= 3'd0;
            if (ent.write_operand_count != 3'd0)
              st_q <= ST_WRITE;
            else if (ent.read_operand_count != 3'd0)
              st_q <= ST_READ;
          end
        ST_WRITE:
          if (wr_data)
          begin
            wleft_q <= wleft_q - 3'd1;
            if (wleft_q == 3'd1)
              st_q <= (rleft_q != 3'd0) ? ST_READ : ST_IDLE;
          end
        ST_READ:
          if (rd_data)
          begin
            rleft_q <= rleft_q - 3'd1;
            ridx_q <= ridx_q + 3'd1;
            if (rleft_q == 3'd1)
              st_q <= ST_IDLE;
          end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // Write-ready drops for the cycle after each word, and stays low while the read state lasts, giving the
  // sequencer time to settle before the next word is taken.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      write_avail_bit_q <= 1'b1;
    else if (wr_data)
      write_avail_bit_q <= 1'b0;
    else
      write_avail_bit_q <= (st_q != ST_READ);
  end

  // Read-ready rises once a result word is latched and drops on its read.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      read_avail_bit_q <= 1'b0;
      rd_word_q <= 16'h0000;
    end
    else if (rd_data)
      read_avail_bit_q <= 1'b0;
    else if (st_q == ST_READ && !read_avail_bit_q)
    begin
      read_avail_bit_q <= 1'b1;
      rd_word_q <= rd_next;
    end
  end

  // Result word for the current command and operand index.
  always_comb
  begin
    rd_next = 16'h0000;
    case (op_q.cmd)
      `OHP_OP_MODE_Q: rd_next = {15'h0000, window_match_select_o};
      `OHP_OP_DET_Q: rd_next = {14'h0000, det_q};
      `OHP_OP_RES_Q: rd_next = pair_q;
      `OHP_OP_DEAD_Q: rd_next = {14'h0000, dead_q};
      `OHP_OP_FRM_Q: rd_next = {15'h0000, frame_words_o};
      `OHP_OP_EVT_Q: rd_next = evt_q;
      `OHP_OP_ID_Q: rd_next = {8'h00, op_q.obj};
      `OHP_OP_TRG_Q:
        case (ridx_q)
          3'd0: rd_next = {4'h0, win_w_q};
          3'd1: rd_next = {4'h0, win_o_q};
          3'd2: rd_next = {4'h0, srch_q};
          3'd3: rd_next = {4'h0, rej_q};
          default: rd_next = {15'h0000, trigger_subtract_o};
        endcase
      default: rd_next = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration store
  // ----------------------------------------------------------------
  logic launch;
  logic op_wr;
  assign launch = (st_q == ST_IDLE) && wr_data && obj_ok && ent.write_operand_count == 3'd0;
  assign op_wr = (st_q == ST_WRITE) && wr_data && wleft_q == 3'd1;

  // Operand values written by the operand word of each write command.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      win_w_q <= `OHP_RST_WIN_W;
      win_o_q <= `OHP_RST_WIN_O;
      srch_q <= `OHP_RST_SRCH;
      rej_q <= `OHP_RST_REJ;
      det_q <= 2'd0;
      step_q <= 2'd0;
      dead_q <= 2'd0;
      pair_q <= `OHP_RST_PAIR;
      evt_q <= `OHP_RST_EVT;
    end
    else if (op_wr)
    begin
      case (op_q.cmd)
        `OHP_OP_WIN_W: win_w_q <= wdat[11:0];
        `OHP_OP_WIN_O: win_o_q <= wdat[11:0];
        `OHP_OP_SRCH: srch_q <= wdat[11:0];
        `OHP_OP_REJ: rej_q <= wdat[11:0];
        `OHP_OP_DET_W: det_q <= wdat[1:0];
        `OHP_OP_STEP_W: step_q <= wdat[1:0];
        `OHP_OP_PAIR_W: pair_q <= wdat;
        `OHP_OP_DEAD_W: dead_q <= wdat[1:0];
        `OHP_OP_EVT_W: evt_q <= wdat;
        default: evt_q <= evt_q;
      endcase
    end
  end

  // Mode flags set by operand-free commands.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      window_match_select_o <= 1'b0;
      auto_reject_o <= 1'b0;
      hold_token_o <= 1'b0;
      trigger_subtract_o <= 1'b0;
      frame_words_o <= 1'b1;
      boot_custom_o <= 1'b0;
    end
    else if (launch)
    begin
      case (op_in.cmd)
        `OHP_OP_MATCH:
        begin
          window_match_select_o <= 1'b1;
          auto_reject_o <= 1'b1;
          hold_token_o <= 1'b1;
        end
        `OHP_OP_STREAM:
        begin
          window_match_select_o <= 1'b0;
          auto_reject_o <= 1'b0;
          trigger_subtract_o <= 1'b0;
        end
        `OHP_OP_KEEP_ON: hold_token_o <= 1'b1;
        `OHP_OP_KEEP_OFF: hold_token_o <= 1'b0;
        `OHP_OP_FACTORY: window_match_select_o <= 1'b0;
        `OHP_OP_SUB_ON: trigger_subtract_o <= 1'b1;
        `OHP_OP_SUB_OFF: trigger_subtract_o <= 1'b0;
        `OHP_OP_FRM_ON: frame_words_o <= 1'b1;
        `OHP_OP_FRM_OFF: frame_words_o <= 1'b0;
        `OHP_OP_BOOT_CUST: boot_custom_o <= 1'b1;
        `OHP_OP_BOOT_FACT: boot_custom_o <= 1'b0;
        default: boot_custom_o <= boot_custom_o;
      endcase
    end
  end

  // One enable flip-flop per channel; the narrow variant keeps the top half off.
  genvar g;
  generate
    for (g = 0; g < 128; g++)
    begin : g_ch
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          ch_enable_o[g] <= (WIDE || g < 64);
        else if (launch && op_in.obj == 8'(g) && (WIDE || g < 64))
        begin
          if (op_in.cmd == `OHP_OP_CH_ON)
            ch_enable_o[g] <= 1'b1;
          else if (op_in.cmd == `OHP_OP_CH_OFF)
            ch_enable_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Reprogram pulses fire as the command launches or its last operand lands.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      setup_reprog_o <= 1'b0;
      ctrl_reprog_o <= 1'b0;
      data_clear_o <= 1'b0;
    end
    else
    begin
      setup_reprog_o <= (launch && ent.reprogram_class == OHP_RP_SETUP) || op_wr;
      data_clear_o <= (launch && ent.reprogram_class == OHP_RP_SETUP) || op_wr;
      ctrl_reprog_o <= launch && ent.reprogram_class == OHP_RP_CTRL;
    end
  end

  // ----------------------------------------------------------------
  // Register readback
  // ----------------------------------------------------------------
  // Unmapped addresses read zero; the data and event words are 16 bits wide.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req && !wb_we_i)
    begin
      if (wb_adr_i == `OHP_ADR_DATA)
        wb_dat_o <= {16'h0000, rd_word_q};
      else if (wb_adr_i == `OHP_ADR_HSK)
        wb_dat_o <= {30'h0, read_avail_bit_q, write_avail_bit_q};
      else if (wb_adr_i == `OHP_ADR_MODE)
        wb_dat_o <= {24'h0, step_q, boot_custom_o, frame_words_o, trigger_subtract_o,
          hold_token_o, auto_reject_o, window_match_select_o};
      else if (wb_adr_i == `OHP_ADR_EVT)
        wb_dat_o <= {16'h0000, evt_q};
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

endmodule : ohp_port

// >>> ohp_port_props.sv
// Concurrent checks on the ports of the opcode handshake port.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module ohp_port_props
  import ohp_pkg::*;
(
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic wb_cyc_i, // Cycle.
  input wire logic wb_stb_i, // Strobe.
  input wire logic wb_we_i, // Write enable.
  input wire logic [7:0] wb_adr_i, // Address.
  input wire logic [3:0] wb_sel_i, // Byte selects.
  input wire logic [31:0] wb_dat_i, // Write data.
  input wire logic [31:0] wb_dat_o, // Read data.
  input wire logic wb_ack_o, // Acknowledge.
  input wire logic setup_reprog_o, // Setup pulse.
  input wire logic ctrl_reprog_o, // Control pulse.
  input wire logic data_clear_o, // Clear pulse.
  input wire logic window_match_select_o, // Match mode.
  input wire logic auto_reject_o, // Reject.
  input wire logic hold_token_o, // Hold token.
  input wire logic trigger_subtract_o, // Subtraction.
  input wire logic frame_words_o, // Frame words.
  input wire logic boot_custom_o, // Boot choice.
  input wire logic [127:0] ch_enable_o // Channel enables.
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A write to the data port taken at this edge.
  logic wr_data;
  assign wr_data = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00;
  sequence taken_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_once_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_pulse_a: assert property (taken_s |=> ack_once_s)
    else $error("ack is not a single pulse after a request");
  sub_cause_a: assert property ($rose(trigger_subtract_o) |->
    $past(wr_data) && $past(wb_dat_i[15:8]) == 8'h14 && setup_reprog_o)
    else $error("subtraction rose without its command");
  clear_pair_a: assert property (setup_reprog_o == data_clear_o)
    else $error("setup reprogram and data clear differ");
  ctrl_clean_a: assert property (ctrl_reprog_o |-> !data_clear_o)
    else $error("control reprogram cleared data");
  match_on_a: assert property ($rose(window_match_select_o) |->
    auto_reject_o && hold_token_o && setup_reprog_o)
    else $error("match mode without reject and hold");
  stream_off_a: assert property ($fell(window_match_select_o) |->
    !auto_reject_o && !trigger_subtract_o)
    else $error("stream mode kept reject or subtraction");
  boot_quiet_a: assert property ($changed(boot_custom_o) |->
    !setup_reprog_o && !ctrl_reprog_o)
    else $error("boot choice caused a reprogram");
  frame_cause_a: assert property ($changed(frame_words_o) |-> setup_reprog_o)
    else $error("frame setting changed without setup reprogram");
  chan_cause_a: assert property ($changed(ch_enable_o) |-> ctrl_reprog_o &&
    $past(wr_data) && $past(wb_dat_i[15:9]) == 7'h20)
    else $error("channel enable changed without its command");
  hold_off_a: assert property ($fell(hold_token_o) |-> setup_reprog_o)
    else $error("hold token cleared without setup reprogram");
endmodule : ohp_port_props
bind ohp_port ohp_port_props ohp_port_props_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .setup_reprog_o(setup_reprog_o), .ctrl_reprog_o(ctrl_reprog_o),
  .data_clear_o(data_clear_o), .window_match_select_o(window_match_select_o),
  .auto_reject_o(auto_reject_o), .hold_token_o(hold_token_o),
  .trigger_subtract_o(trigger_subtract_o), .frame_words_o(frame_words_o),
  .boot_custom_o(boot_custom_o), .ch_enable_o(ch_enable_o));

// >>> ohp_host.sv
// Classic Wishbone master standing for the host at the command port.
// Assumes the bench raises go_i after a clock edge and drops it on done_o.
`timescale 1ns/1ps
module ohp_host (
  input wire logic clk_i, // Clock.
  input wire logic rst_i, // Reset.
  input wire logic go_i, // Request a transfer.
  input wire logic we_i, // Direction.
  input wire logic [7:0] adr_i, // Address.
  input wire logic [31:0] dat_i, // Write data.
  input wire logic wb_ack_i, // Slave acknowledge.
  input wire logic [31:0] wb_dat_i, // Slave read data.
  output logic wb_cyc_o, // Cycle.
  output logic wb_stb_o, // Strobe.
  output logic wb_we_o, // Write enable.
  output logic [7:0] wb_adr_o, // Address.
  output logic [3:0] wb_sel_o, // Byte selects.
  output logic [31:0] wb_dat_o, // Write data.
  output logic done_o, // One-cycle completion.
  output logic [31:0] rdat_o // Read data taken at ack.
);
  // ------------------------------------------------------------
  // Bus cycle
  // ------------------------------------------------------------
  // Released direction, address and data lines are inverted so that a slave using stale values is caught.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o <= 1'b0;
      wb_adr_o <= 8'h00;
      wb_sel_o <= 4'h0;
      wb_dat_o <= 32'h0;
      done_o <= 1'b0;
      rdat_o <= 32'h0;
    end
    else if (wb_cyc_o && wb_ack_i)
    begin
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o <= ~wb_we_o;
      wb_adr_o <= ~wb_adr_o;
      wb_sel_o <= 4'h0;
      wb_dat_o <= ~wb_dat_o;
      rdat_o <= wb_dat_i;
      done_o <= 1'b1;
    end
    else if (!wb_cyc_o && go_i && !done_o)
    begin
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we_i;
      wb_adr_o <= adr_i;
      wb_sel_o <= 4'hf;
      wb_dat_o <= dat_i;
    end
    else
      done_o <= 1'b0;
  end
endmodule : ohp_host

// >>> test_opcode_handshake_port.sv
// Self-checking bench for the opcode handshake port with a reference model.
// Assumes ohp_host as bus master and the checker bound to the design.
`timescale 1ns/1ps
module test_opcode_handshake_port;
  // ------------------------------------------------------------
  // Signals and model state
  // ------------------------------------------------------------
  logic clk_i = 1'b0, rst_i = 1'b1, go = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rd, rdat, wb_dat_o, wb_dat_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, done, s_rp, c_rp, d_clr;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic mt, rj, hd, sb, fr, bt, mt_o, rj_o, hd_o, sb_o, fr_o, bt_o;
  logic [127:0] ch_en;
  logic [15:0] w;
  logic [15:0] exq[$];
  logic [7:0] codes[12] = '{8'h00, 8'h14, 8'h04, 8'h03, 8'h01, 8'h14, 8'h31, 8'h30,
    8'h08, 8'h09, 8'h00, 8'h15};
  logic [7:0] wc[4] = '{8'h22, 8'h28, 8'h25, 8'h33};
  logic [7:0] rc[4] = '{8'h23, 8'h29, 8'h26, 8'h34};
  logic [15:0] mk[4] = '{16'h0003, 16'h0003, 16'hffff, 16'hffff};
  integer num_errors = 0, num_checks = 0, seed = 32'h692cde51, i;
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  ohp_host ohp_host_i (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .we_i(we), .adr_i(adr),
    .dat_i(wdat), .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o), .wb_cyc_o(wb_cyc_i),
    .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i),
    .wb_dat_o(wb_dat_i), .done_o(done), .rdat_o(rdat));
  ohp_port ohp_port_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .setup_reprog_o(s_rp), .ctrl_reprog_o(c_rp), .data_clear_o(d_clr),
    .window_match_select_o(mt_o), .auto_reject_o(rj_o), .hold_token_o(hd_o),
    .trigger_subtract_o(sb_o), .frame_words_o(fr_o), .boot_custom_o(bt_o),
    .ch_enable_o(ch_en));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task print_verdict;
    $display("Errors %0d, checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // One Wishbone cycle; a hang ends the run through the verdict.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge clk_i);
    go <= 1'b1;
    we <= wr;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (done !== 1'b1)
    begin
      n++;
      if (n > 100)
      begin
        num_errors++;
        $display("FAIL at %0t: bus cycle never ended", $time);
        print_verdict;
      end
      @(posedge clk_i);
    end
    go <= 1'b0;
    rd = rdat;
  endtask : bus
  // Polls the handshake until the given flag is set, under a bound.
  task poll(input int b);
    integer n;
    n = 0;
    rd = 32'h0;
    while (rd[b] !== 1'b1 && n < 50)
    begin
      bus(1'b0, 8'h04, 32'h0);
      n++;
    end
    chk({31'h0, rd[b]}, 32'h1);
  endtask : poll
  task put(input logic [15:0] x);
    poll(0);
    bus(1'b1, 8'h00, {16'h0, x});
  endtask : put
  task getc;
    logic [15:0] e;
    e = exq.pop_front();
    poll(1);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, {16'h0, e});
  endtask : getc
  task cmpmode;
    bus(1'b0, 8'h08, 32'h0);
    chk({26'h0, rd[5:0]}, {26'h0, bt, fr, sb, hd, rj, mt});
    chk({26'h0, bt_o, fr_o, sb_o, hd_o, rj_o, mt_o}, {26'h0, bt, fr, sb, hd, rj, mt});
  endtask : cmpmode
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {mt, rj, hd, sb, fr, bt} = 6'b000010;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({31'h0, &ch_en}, 32'h1);
    bus(1'b0, 8'h04, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h1);
    cmpmode;
    // Mode commands with a random object byte, which must not matter.
    for (i = 0; i < 12; i++)
    begin
      put({codes[i], 8'($random(seed))});
      case (codes[i])
        8'h00: {mt, rj, hd} = 3'b111;
        8'h01: {mt, rj, sb} = 3'b000;
        8'h03: hd = 1'b1;
        8'h04: hd = 1'b0;
        8'h14: sb = 1'b1;
        8'h15: sb = 1'b0;
        8'h30: fr = 1'b1;
        8'h31: fr = 1'b0;
        8'h08: bt = 1'b1;
        8'h09: bt = 1'b0;
        default: ;
      endcase
      cmpmode;
    end
    put(16'h0200);
    bus(1'b0, 8'h04, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h2);
    exq.push_back({15'h0, mt});
    getc;
    // Window, search and reject values keep only their low twelve bits.
    for (i = 0; i < 4; i++)
    begin
      w = 16'($random(seed));
      put({8'h10 + 8'(i), 8'h00});
      put(w);
      exq.push_back({4'h0, w[11:0]});
    end
    exq.push_back({15'h0, sb});
    put(16'h1600);
    repeat (5) getc;
    for (i = 0; i < 4; i++)
    begin
      w = 16'($random(seed));
      put({wc[i], 8'h00});
      put(w);
      put({rc[i], 8'h00});
      exq.push_back(w & mk[i]);
      getc;
    end
    put(16'h2400);
    put(16'h0002);
    bus(1'b0, 8'h08, 32'h0);
    chk({30'h0, rd[7:6]}, 32'h2);
    bus(1'b0, 8'h04, 32'h0);
    chk({31'h0, rd[1]}, 32'h0);
    put(16'h417f);
    chk({31'h0, ch_en[127]}, 32'h0);
    put(16'h4180);
    chk({31'h0, ch_en[0]}, 32'h1);
    put(16'h407f);
    chk({31'h0, &ch_en}, 32'h1);
    put(16'h6003);
    exq.push_back(16'h0003);
    exq.push_back(16'h0003);
    repeat (2) getc;
    put(16'h6004);
    repeat (4) @(posedge clk_i);
    bus(1'b0, 8'h04, 32'h0);
    chk({31'h0, rd[1]}, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    print_verdict;
  end
endmodule : test_opcode_handshake_port
